// ===== hdl/amseq_pkg.sv
// Constants, types and register map of the converter mux sequencer
//--------------------------------------------------------------------
// What this block does
// RULE1: Regular frame selects current_a, voltage_a, current_b, voltage_b; alternate differs
// RULE2: mux_state_count picks 2, 3 or 4 states; larger values are reserved
// RULE3: Frame starts at state 0 and runs exactly mux_state_count states
// RULE4: Alt request rising edge: finish frame, run one alternate frame, return
// RULE5: Alt request may pulse for one cycle and is still captured
// RULE6: All sequencer state advances on the low-rate clock
// RULE7: Sequencer starts filter for each conversion and drives reference chopper
// RULE8: filter_length_select 0 gives 21-bit results, 1 gives 22-bit
// RULE9: Conversion lasts two cycles, or three with filter_length_select set
// RULE10: Conversion end writes result to the word of the selected input
// RULE11: Stored result is LSB aligned then shifted left nine bits
// RULE12: chopper_mode: positive holds low, reverse holds high, chop toggles
// RULE13: One idle cycle after each frame; reference_swap updates at its start
// RULE14: frame_sync high during idle cycle; its leading edge starts engine pass
// RULE15: Chop skips toggle after final frame of an accumulation cycle
// RULE16: Battery enabled: converted in alternate frames, stored at address 07
// RULE17: Without main power battery_measure_enable reads as zero; a read of 0x2020 still returns the written bit, only 0x2012 bit 6 reads zero
// RULE18: Engine program counter restarts when mux state 0 begins
// RULE19: battery_measure_enable is bit 6 of control byte at 0x2020
// RULE20: Pending alt request clears when the alternate frame begins
// RULE21: Mode settings are sampled only at frame boundaries
//--------------------------------------------------------------------
package amseq_pkg;
  // Register offsets
  localparam logic [15:0] OFS_CHOPPER_CONTROL = 16'h2002;
  localparam logic [15:0] OFS_BATTERY_CONTROL = 16'h2020;
  localparam logic [15:0] OFS_MUX_CONFIG = 16'h2010;
  localparam logic [15:0] OFS_ACCUM_LENGTH = 16'h2011;
  localparam logic [15:0] OFS_STATUS = 16'h2012;
  // Field positions
  localparam int CHOP_LSB = 4;
  localparam int BATT_EN_BIT = 6;
  localparam int CFG_COUNT_LSB = 0;
  localparam int CFG_LONG_BIT = 3;
  localparam int CFG_EQU_LSB = 4;
  localparam int CFG_ALT_BIT = 7;
  // Reset values
  localparam logic [1:0] CHOP_RESET = 2'h1;
  localparam logic [2:0] COUNT_RESET = 3'h4;
  localparam logic [7:0] ACCUM_RESET = 8'h01;
  // Chopper modes
  localparam logic [1:0] CHOP_TOGGLE = 2'h0;
  localparam logic [1:0] CHOP_POSITIVE = 2'h1;
  localparam logic [1:0] CHOP_REVERSE = 2'h2;
  // State counts and index of the last low-rate cycle of a conversion
  localparam logic [2:0] COUNT_MIN = 3'h2;
  localparam logic [2:0] COUNT_MAX = 3'h4;
  localparam logic [1:0] CONV_SHORT_LAST = 2'h1;
  localparam logic [1:0] CONV_LONG_LAST = 2'h2;
  // Result widths and placement
  localparam int RES_SHORT_BITS = 21;
  localparam int RES_LONG_BITS = 22;
  localparam int RES_SHIFT = 9;
  // Sample memory words of each input
  localparam logic [6:0] ADDR_CURRENT_A = 7'h00;
  localparam logic [6:0] ADDR_VOLTAGE_A = 7'h01;
  localparam logic [6:0] ADDR_CURRENT_B = 7'h02;
  localparam logic [6:0] ADDR_VOLTAGE_B = 7'h03;
  localparam logic [6:0] ADDR_TEMPERATURE = 7'h06;
  localparam logic [6:0] ADDR_BATTERY = 7'h07;

  typedef enum logic [1:0] {
    ST_CONV = 2'b01,
    ST_SYNC = 2'b10
  } amseq_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } amseq_bus_type;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [31:0] data;
  } amseq_mem_type;
endpackage

// ===== hdl/amseq_sequencer.sv
// Converter mux sequencer: frame stepping, storage, chopper, frame sync
//
// Chosen here: the plain strobed port.
module amseq_sequencer (
  // Clock (the low-rate sequencer clock) and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire amseq_pkg::amseq_bus_type regBus,
  output logic [7:0] regRdata,
  // Converter and filter
  input wire logic [21:0] filterResult,
  output logic [6:0] muxSelect,
  output logic convStart,
  // Sample memory write port
  output amseq_pkg::amseq_mem_type memWr,
  // Reference and power
  input wire logic mainPowerOk,
  output logic referenceSwap,
  output logic batteryLoadEn,
  // Compute engine
  output logic frameSync,
  output logic passStart,
  output logic pcRestart
);
  import amseq_pkg::*;

  //--------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------
  amseq_state_type state_r;
  amseq_state_type state_nxt;
  logic [1:0] chopMode_r;
  logic battEn_r;
  logic [2:0] muxCount_r;
  logic filterLong_r;
  logic [1:0] equSel_r;
  logic altReq_r;
  logic altReqPrev_r;
  logic altPending_r;
  logic [7:0] accumLen_r;
  logic [7:0] frameCnt_r;
  logic [2:0] cfgCount_r;
  logic cfgLong_r;
  logic [1:0] cfgChop_r;
  logic altFrame_r;
  logic cfgBatt_r;
  logic [1:0] stateIdx_r;
  logic [1:0] cycleCnt_r;
  logic swap_r;
  logic syncPrev_r;
  logic [7:0] rdata_r;
  amseq_mem_type mem_r;
  logic battEffective;
  logic altRise;
  logic convLast;
  logic frameLast;
  logic accumLast;
  logic [1:0] convLastCnt;

  // Input word for a state; alternate list keeps voltage_a in place
  function automatic logic [6:0] inputAddr(input logic alt, input logic [1:0] idx);
    logic [6:0] a;
    a = ADDR_CURRENT_A;
    unique case (idx)
      2'd0: a = alt ? ADDR_TEMPERATURE : ADDR_CURRENT_A;
      2'd1: a = ADDR_VOLTAGE_A;
      2'd2: a = ADDR_CURRENT_B;
      2'd3: a = alt ? ADDR_BATTERY : ADDR_VOLTAGE_B;
    endcase
    return a;
  endfunction

  // Clamp reserved state counts so a bad write cannot hang a frame
  function automatic logic [2:0] legalCount(input logic [2:0] c);
    logic [2:0] r;
    r = c;
    if (c > COUNT_MAX) begin
      r = COUNT_MAX;
    end else if (c < COUNT_MIN) begin
      r = COUNT_MIN;
    end
    return r;
  endfunction

  //--------------------------------------------------------------
  // Register writes
  //--------------------------------------------------------------
  // Chopper mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chopMode_r <= CHOP_RESET;
    end else if (regBus.wr && regBus.addr == OFS_CHOPPER_CONTROL) begin
      chopMode_r <= regBus.wdata[CHOP_LSB +: 2];
    end
  end

  // Battery measurement enable, off by default to spare the battery
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      battEn_r <= 1'b0;
    end else if (regBus.wr && regBus.addr == OFS_BATTERY_CONTROL) begin
      battEn_r <= regBus.wdata[BATT_EN_BIT]; // RULE19
    end
  end

  // Mux configuration and alternate request bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      muxCount_r <= COUNT_RESET;
      filterLong_r <= 1'b1;
      equSel_r <= 2'h0;
      altReq_r <= 1'b0;
    end else if (regBus.wr && regBus.addr == OFS_MUX_CONFIG) begin
      muxCount_r <= regBus.wdata[CFG_COUNT_LSB +: 3];
      filterLong_r <= regBus.wdata[CFG_LONG_BIT];
      equSel_r <= regBus.wdata[CFG_EQU_LSB +: 2];
      altReq_r <= regBus.wdata[CFG_ALT_BIT];
    end
  end

  // Frames per accumulation cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accumLen_r <= ACCUM_RESET;
    end else if (regBus.wr && regBus.addr == OFS_ACCUM_LENGTH) begin
      accumLen_r <= regBus.wdata;
    end
  end

  //--------------------------------------------------------------
  // Register reads
  //--------------------------------------------------------------
  // Data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (regBus.rd) begin
      unique case (regBus.addr)
        OFS_CHOPPER_CONTROL: rdata_r <= {2'h0, chopMode_r, 4'h0};
        OFS_BATTERY_CONTROL: rdata_r <= {1'b0, battEn_r, 6'h00};
        OFS_MUX_CONFIG: rdata_r <= {altReq_r, 1'b0, equSel_r, filterLong_r, muxCount_r};
        OFS_ACCUM_LENGTH: rdata_r <= accumLen_r;
        OFS_STATUS: rdata_r <= {1'b0, battEffective, frameSync, altPending_r,
                                swap_r, altFrame_r, stateIdx_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign regRdata = rdata_r;

  //--------------------------------------------------------------
  // Alternate frame request
  //--------------------------------------------------------------
  // Battery load is only allowed while main power is present
  assign battEffective = battEn_r && mainPowerOk; // RULE17
  assign altRise = altReq_r && !altReqPrev_r;

  // Edge memory; a one-cycle pulse of the bit is still one edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      altReqPrev_r <= 1'b0;
    end else begin
      altReqPrev_r <= altReq_r; // RULE5
    end
  end

  // Pending flag, cleared in every sync cycle. An edge in the sync cycle
  // itself goes straight into the frame latch, so keeping it pending too
  // would buy a second alternate frame for a single edge.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      altPending_r <= 1'b0;
    end else if (state_r == ST_SYNC) begin
      altPending_r <= 1'b0; // RULE20
    end else if (altRise) begin
      altPending_r <= 1'b1; // RULE5
    end
  end

  //--------------------------------------------------------------
  // Frame sequencing
  //--------------------------------------------------------------
  assign convLastCnt = cfgLong_r ? CONV_LONG_LAST : CONV_SHORT_LAST; // RULE9
  assign convLast = (state_r == ST_CONV) && (cycleCnt_r == convLastCnt);
  assign frameLast = convLast && ({1'b0, stateIdx_r} == cfgCount_r - 3'h1); // RULE3
  // Lengths 0 and 1 make every frame the last of its accumulation cycle
  assign accumLast = (accumLen_r <= 8'h01) || (frameCnt_r >= accumLen_r - 8'h01);

  // Next state: conversions, then exactly one sync cycle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_CONV: begin
        if (frameLast) begin
          state_nxt = ST_SYNC; // RULE13
        end
      end
      ST_SYNC: state_nxt = ST_CONV;
      default: state_nxt = ST_SYNC;
    endcase
  end

  // Reset lands in a sync cycle so the first frame starts cleanly
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_SYNC;
    end else begin
      state_r <= state_nxt; // RULE6
    end
  end

  // State index and cycle within the conversion
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stateIdx_r <= 2'd0;
      cycleCnt_r <= 2'd0;
    end else if (state_r == ST_SYNC) begin
      stateIdx_r <= 2'd0; // RULE3
      cycleCnt_r <= 2'd0;
    end else if (convLast) begin
      stateIdx_r <= stateIdx_r + 2'd1;
      cycleCnt_r <= 2'd0;
    end else begin
      cycleCnt_r <= cycleCnt_r + 2'd1; // RULE9
    end
  end

  // Frame settings are latched in the sync cycle only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgCount_r <= COUNT_RESET;
      cfgLong_r <= 1'b1;
      cfgChop_r <= CHOP_RESET;
      altFrame_r <= 1'b0;
      cfgBatt_r <= 1'b0;
    end else if (state_r == ST_SYNC) begin
      cfgCount_r <= legalCount(muxCount_r); // RULE2
      cfgLong_r <= filterLong_r; // RULE21
      cfgChop_r <= chopMode_r; // RULE21
      altFrame_r <= altPending_r || altRise; // RULE4
      cfgBatt_r <= battEffective;
    end
  end

  // Frame counter within the accumulation cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frameCnt_r <= 8'h00;
    end else if (frameLast) begin
      frameCnt_r <= accumLast ? 8'h00 : frameCnt_r + 8'h01;
    end
  end

  //--------------------------------------------------------------
  // Reference chopper
  //--------------------------------------------------------------
  // Updated on entry to the sync cycle so the reference settles
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      swap_r <= 1'b0;
    end else if (frameLast) begin
      unique case (chopMode_r)
        CHOP_POSITIVE: swap_r <= 1'b0; // RULE12
        CHOP_REVERSE: swap_r <= 1'b1; // RULE12
        default: swap_r <= accumLast ? swap_r : !swap_r; // RULE15
      endcase
    end
  end

  assign referenceSwap = swap_r; // RULE7

  //--------------------------------------------------------------
  // Converter control and result storage
  //--------------------------------------------------------------
  assign muxSelect = inputAddr(altFrame_r, stateIdx_r); // RULE1
  // Filter restarts on the first cycle of every conversion
  assign convStart = (state_r == ST_CONV) && (cycleCnt_r == 2'd0); // RULE7

  // Result written the cycle after the conversion ends
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_r <= '0;
    end else if (convLast) begin
      // Battery word is skipped when the monitor is off
      mem_r.we <= !(altFrame_r && stateIdx_r == 2'd3 && !cfgBatt_r); // RULE16
      mem_r.addr <= inputAddr(altFrame_r, stateIdx_r); // RULE10
      // Short results keep two zero bits on top; the filter's top bit is dropped
      if (cfgLong_r) begin
        mem_r.data <= {1'b0, filterResult[RES_LONG_BITS-1:0], 9'h000}; // RULE11
      end else begin
        mem_r.data <= {2'h0, filterResult[RES_SHORT_BITS-1:0], 9'h000}; // RULE8
      end
    end else begin
      mem_r.we <= 1'b0;
    end
  end

  assign memWr = mem_r;

  //--------------------------------------------------------------
  // Engine synchronisation
  //--------------------------------------------------------------
  // Starts high: reset parks in a sync cycle, so that cycle raises no
  // pass start; only sync cycles that end a frame start an engine pass
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncPrev_r <= 1'b1;
    end else begin
      syncPrev_r <= frameSync;
    end
  end

  assign frameSync = (state_r == ST_SYNC); // RULE14
  assign passStart = frameSync && !syncPrev_r; // RULE14
  assign pcRestart = (state_r == ST_CONV) && syncPrev_r; // RULE18
  assign batteryLoadEn = cfgBatt_r && mainPowerOk && altFrame_r; // RULE16

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Swap checks look one edge past frameLast and store checks one edge past convLast, where each lands

  AST_ALT_LIST: assert property (altFrame_r && state_r == ST_CONV && stateIdx_r == 2'd0 // RULE1
    |-> muxSelect == ADDR_TEMPERATURE) else $error("alternate state 0 not temperature");
  AST_COUNT_LEGAL: assert property (cfgCount_r >= COUNT_MIN && cfgCount_r <= COUNT_MAX) // RULE2
    else $error("illegal state count");
  AST_FRAME_LEN: assert property ($rose(frameSync) // RULE3
    |-> {1'b0, $past(stateIdx_r)} == cfgCount_r - 3'h1) else $error("frame length wrong");
  AST_ALT_ONCE: assert property (altFrame_r && frameSync && !altPending_r && !altRise // RULE4
    |=> !altFrame_r) else $error("extra alternate frame");
  AST_ALT_CAPTURE: assert property (altRise |=> altPending_r || altFrame_r) // RULE5
    else $error("alternate request lost");
  AST_CONV_LONG: assert property (convStart && cfgLong_r // RULE9
    |=> !convStart ##1 !convStart ##1 (convStart || frameSync)) else $error("long conv");
  AST_CONV_SHORT: assert property (convStart && !cfgLong_r // RULE9
    |=> !convStart ##1 (convStart || frameSync)) else $error("short conversion");
  AST_STORE: assert property (convLast |=> (mem_r.data[8:0] == 9'h000) // RULE11
    && mem_r.addr == $past(muxSelect)) else $error("store misplaced");
  AST_SYNC_ONE: assert property ($rose(frameSync) |=> !frameSync ##1 !frameSync) // RULE13
    else $error("sync not one cycle");
  AST_SWAP_WHEN: assert property ($changed(referenceSwap) |-> $rose(frameSync)) // RULE13
    else $error("swap changed mid frame");
  AST_SWAP_POS: assert property (frameLast && chopMode_r == CHOP_POSITIVE // RULE12
    |=> !referenceSwap) else $error("positive mode swap high");
  AST_SWAP_REV: assert property (frameLast && chopMode_r == CHOP_REVERSE // RULE12
    |=> referenceSwap) else $error("reverse mode swap low");
  AST_CHOP_FINAL: assert property (frameLast && accumLast && chopMode_r == CHOP_TOGGLE // RULE15
    |=> $stable(referenceSwap)) else $error("toggle after final frame");
  AST_BATT_POWER: assert property (!mainPowerOk |-> !batteryLoadEn) // RULE17
    else $error("battery load without power");
  AST_BATT_LATCH: assert property (frameSync && !mainPowerOk |=> !cfgBatt_r) // RULE17
    else $error("battery enabled without power");
  AST_BATT_STORE: assert property (convLast && altFrame_r && stateIdx_r == 2'd3 // RULE16
    |=> mem_r.we == cfgBatt_r && mem_r.addr == ADDR_BATTERY) else $error("battery store");
  AST_PC_RESTART: assert property (pcRestart |-> stateIdx_r == 2'd0 && $past(frameSync)) // RULE18
    else $error("restart not at state 0");
  AST_PC_AFTER_SYNC: assert property (frameSync |=> pcRestart && stateIdx_r == 2'd0) // RULE18
    else $error("no restart after sync");
  AST_ALT_CLEAR: assert property (frameSync |=> !altPending_r) // RULE20
    else $error("pending request survived frame start");
  AST_CONV_FIRST: assert property (pcRestart |-> convStart) // RULE3
    else $error("frame does not open with a conversion");
  AST_CFG_HOLD: assert property (!frameSync // RULE21
    |=> $stable(cfgCount_r) && $stable(cfgLong_r) && $stable(altFrame_r))
    else $error("frame settings changed mid frame");

  // Main scenarios: alternate frame, chopping, battery, three-state frames, reverse
  COV_ALT_FRAME: cover property (altRise ##[1:40] (altFrame_r && frameSync));
  COV_CHOP: cover property (frameSync && cfgChop_r == CHOP_TOGGLE ##[1:20] $rose(frameSync));
  COV_BATT: cover property (mem_r.we && mem_r.addr == ADDR_BATTERY);
  COV_THREE: cover property (frameSync && cfgCount_r == 3'h3);
  COV_REVERSE: cover property (frameSync && referenceSwap && cfgChop_r == CHOP_REVERSE);
endmodule

// ===== sim/amseq_far_model.sv
// Far-side model: filter output source and sample memory of the compute engine
module amseq_far_model (
  // Clock
  input wire logic clk,
  // Sequencer side
  input wire logic convStart,
  input wire logic frameSync,
  input wire logic [6:0] muxSelect,
  input wire amseq_pkg::amseq_mem_type memWr,
  output logic [21:0] filterResult
);
  timeunit 1ns;
  timeprecision 1ps;
  import amseq_pkg::*;
  logic [21:0] heldResult = 22'h000000;
  logic convLive = 1'b0;
  logic [31:0] mem [0:7];
  int wrCount [0:7] = '{default: 0};
  //----------------------------------------
  // Filter output
  //----------------------------------------
  // Result tagged by input; top bit set so a 21-bit store must drop it
  always_ff @(posedge clk) begin
    if (convStart) begin
      heldResult <= {1'b1, 14'h0000, muxSelect};
      convLive <= 1'b1;
    end else if (frameSync) begin
      convLive <= 1'b0;
    end
  end
  // Junk until the first conversion and in the first cycle of each frame; the held value otherwise
  assign filterResult = convLive ? heldResult : ~heldResult;
  //----------------------------------------
  // Sample memory
  //----------------------------------------
  // Only the eight converter words exist here
  always_ff @(posedge clk) begin
    if (memWr.we) begin
      mem[memWr.addr[2:0]] <= memWr.data;
      wrCount[memWr.addr[2:0]] <= wrCount[memWr.addr[2:0]] + 1;
    end
  end
endmodule

// ===== sim/amseq_sequencer_tb.sv
// Self-checking testbench of the converter mux sequencer
module amseq_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import amseq_pkg::*;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  amseq_bus_type regBus = '0;
  logic [7:0] regRdata;
  logic [21:0] filterResult;
  logic [6:0] muxSelect;
  logic convStart;
  amseq_mem_type memWr;
  logic mainPowerOk = 1'b1;
  logic referenceSwap;
  logic batteryLoadEn;
  logic frameSync;
  logic passStart;
  logic pcRestart;
  logic battExp = 1'b0;
  logic swap;
  logic [4:0] sw;
  int mismatches = 0;
  int tests_run = 0;
  int cnt;
  logic [6:0] regList [4] = '{ADDR_CURRENT_A, ADDR_VOLTAGE_A, ADDR_CURRENT_B, ADDR_VOLTAGE_B};
  logic [6:0] altList [4] = '{ADDR_TEMPERATURE, ADDR_VOLTAGE_A, ADDR_CURRENT_B, ADDR_BATTERY};

  amseq_sequencer amseq_sequencer_inst (.clk(clk), .sys_rst(sysRst), .regBus(regBus),
    .regRdata(regRdata), .filterResult(filterResult), .muxSelect(muxSelect),
    .convStart(convStart), .memWr(memWr), .mainPowerOk(mainPowerOk),
    .referenceSwap(referenceSwap), .batteryLoadEn(batteryLoadEn), .frameSync(frameSync),
    .passStart(passStart), .pcRestart(pcRestart));
  amseq_far_model amseq_far_model_inst (.clk(clk), .convStart(convStart),
    .frameSync(frameSync), .muxSelect(muxSelect), .memWr(memWr),
    .filterResult(filterResult));

  // Low-rate clock stand-in, 10 ns period
  initial forever #5 clk = ~clk;

  //----------------------------------------
  // Report and compare
  //----------------------------------------
  task automatic conclude;
    $display("Counts: %0d compared, %0d mismatched", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chkV(logic [31:0] got, logic [31:0] exp, string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic chkN(int got, int exp, string what);
    tests_run++;
    if (got != exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask
  // Stored word: 21 or 22 result bits, LSB aligned, moved up nine places
  function automatic logic [31:0] expData(logic [6:0] sel, logic long);
    logic [21:0] r;
    r = {1'b1, 14'h0000, sel};
    return (long ? 32'(r) : 32'(r[20:0])) << RES_SHIFT;
  endfunction

  //----------------------------------------
  // Register port and frame tasks
  //----------------------------------------
  // Strobe is left up so writes can run back to back; idle drops it
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask
  task automatic idle;
    @(posedge clk);
    regBus <= '0;
  endtask
  task automatic rdChk(logic [15:0] a, logic [7:0] e, string what);
    @(posedge clk);
    regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regBus <= '0;
    #1;
    chkV(32'(regRdata), 32'(e), what);
  endtask
  // One-cycle request bit: high in the register for a single cycle
  task automatic altPulse(logic [7:0] cfg);
    wr(OFS_MUX_CONFIG, cfg | 8'h80);
    wr(OFS_MUX_CONFIG, cfg);
    idle;
  endtask
  // Steps off the edge first: callers may return in the launching time step
  task automatic waitSync;
    int n;
    #1;
    for (n = 0; n < 60 && frameSync !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (frameSync !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: no frame sync", $time);
      conclude();
    end
  endtask
  // Follows one whole frame from its first state to its sync cycle
  task automatic grab(int expN, int expL, logic alt, output logic sw0);
    int nConv;
    int len;
    waitSync;
    @(posedge clk);
    #1;
    chkV(32'(frameSync), 0, "sync longer than one cycle");
    chkV(32'(pcRestart), 1, "no restart at state 0");
    chkV(32'(batteryLoadEn), 32'(alt & battExp), "battery load");
    sw0 = referenceSwap;
    nConv = 0;
    len = 0;
    while (frameSync !== 1'b1 && len < 20) begin
      if (convStart === 1'b1 && nConv < 4) begin
        chkV(32'(muxSelect), 32'(alt ? altList[nConv] : regList[nConv]), "input");
        nConv++;
      end
      len++;
      @(posedge clk);
      #1;
    end
    chkN(nConv, expN, "conversions per frame");
    chkN(len, expL, "frame length");
    chkV(32'(passStart), 1, "pass start missing");
  endtask

  //----------------------------------------
  // Main sequence
  //----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    sysRst <= 1'b0;
    rdChk(OFS_CHOPPER_CONTROL, 8'(CHOP_RESET) << CHOP_LSB, "chop reset");
    rdChk(OFS_BATTERY_CONTROL, 8'h00, "battery reset");
    rdChk(16'h2100, 8'h00, "unmapped read");
    $display("test reset done");
    // Every state count in both filter lengths
    for (int lg = 0; lg < 2; lg++) begin
      for (int n = 2; n <= 4; n++) begin
        wr(OFS_MUX_CONFIG, 8'(n) | 8'(lg << CFG_LONG_BIT));
        idle;
        grab(n, n * (lg == 1 ? 3 : 2), 1'b0, swap);
        @(posedge clk);
        #1;
        for (int i = 0; i < n; i++) begin
          chkV(amseq_far_model_inst.mem[regList[i]], expData(regList[i], lg[0]), "data");
        end
      end
    end
    $display("test counts done");
    // Alternate frames: battery off, on, then on without main power
    cnt = amseq_far_model_inst.wrCount[7];
    altPulse(8'h0C);
    grab(4, 12, 1'b1, swap);
    grab(4, 12, 1'b0, swap);
    chkN(amseq_far_model_inst.wrCount[7], cnt, "battery stored while off");
    wr(OFS_BATTERY_CONTROL, 8'h40);
    idle;
    rdChk(OFS_BATTERY_CONTROL, 8'h40, "battery enable bit");
    battExp = 1'b1;
    altPulse(8'h0C);
    grab(4, 12, 1'b1, swap);
    @(posedge clk);
    #1;
    chkV(amseq_far_model_inst.mem[7], expData(ADDR_BATTERY, 1'b1), "battery word");
    cnt = amseq_far_model_inst.wrCount[7];
    mainPowerOk <= 1'b0;
    battExp = 1'b0;
    altPulse(8'h0C);
    grab(4, 12, 1'b1, swap);
    grab(4, 12, 1'b0, swap);
    chkN(amseq_far_model_inst.wrCount[7], cnt, "battery stored without power");
    mainPowerOk <= 1'b1;
    $display("test alternate done");
    // Fixed chopper modes hold the swap line
    wr(OFS_MUX_CONFIG, 8'h02);
    rdChk(OFS_MUX_CONFIG, 8'h02, "mux config");
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CHOPPER_CONTROL, (m == 0 ? CHOP_POSITIVE : CHOP_REVERSE) << CHOP_LSB);
      idle;
      grab(2, 4, 1'b0, swap);
      repeat (2) begin
        grab(2, 4, 1'b0, swap);
        chkV(32'(swap), 32'(m), "fixed swap level");
      end
    end
    // Chop over two-frame accumulations: toggles skip every second frame
    wr(OFS_ACCUM_LENGTH, 8'h02);
    wr(OFS_CHOPPER_CONTROL, CHOP_TOGGLE << CHOP_LSB);
    idle;
    repeat (2) grab(2, 4, 1'b0, swap);
    for (int k = 0; k < 5; k++) begin
      grab(2, 4, 1'b0, swap);
      sw[k] = swap;
    end
    for (int k = 0; k < 3; k++) begin
      chkV(32'((sw[k] ^ sw[k + 1]) ^ (sw[k + 1] ^ sw[k + 2])), 1, "chop pattern");
    end
    // Every frame final: chop never toggles
    wr(OFS_ACCUM_LENGTH, 8'h01);
    idle;
    repeat (2) grab(2, 4, 1'b0, swap);
    for (int k = 0; k < 3; k++) begin
      grab(2, 4, 1'b0, swap);
      sw[k] = swap;
    end
    chkV(32'(sw[0] ^ sw[1]), 0, "chop on final frame");
    chkV(32'(sw[1] ^ sw[2]), 0, "chop on final frame");
    $display("test chopper done");
    conclude();
  end
endmodule
